// ---- rcr_regs.svh ----
// register offsets, field positions and reset values of the read channel control bank
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH
`define RCR_OFF_CHIP_ID 7'h02
`define RCR_OFF_DAMPING 7'h03
`define RCR_OFF_POWER_DOWN 7'h0A
`define RCR_OFF_TIME_CTRL 7'h0B
`define RCR_OFF_DATA_CUTOFF 7'h12
`define RCR_OFF_TEST_CTRL_2 7'h13
`define RCR_OFF_SERVO_CUTOFF 7'h1A
`define RCR_OFF_SERVO_CTRL 7'h1B
`define RCR_OFF_DATA_BOOST 7'h22
`define RCR_OFF_WRITE_PRECOMP 7'h23
`define RCR_OFF_GROUP_DELAY 7'h2A
`define RCR_OFF_INT_MASK 7'h2B
`define RCR_OFF_DATA_THRESH 7'h32
`define RCR_OFF_SERVO_THRESH 7'h3A
`define RCR_OFF_SERVO_QUAL 7'h3B
`define RCR_OFF_BASELINE 7'h42
`define RCR_OFF_RESYNC_1 7'h43
`define RCR_OFF_TEST_CTRL_1 7'h4A
`define RCR_OFF_FB_DIVIDER 7'h52
`define RCR_OFF_RESYNC_2 7'h53
`define RCR_OFF_REF_DIVIDER 7'h5A
`define RCR_OFF_DATA_RATE 7'h62
`define RCR_OFF_COAST_1 7'h63
`define RCR_OFF_SEQUENCE 7'h6A
`define RCR_OFF_MODE_1 7'h72
`define RCR_OFF_COAST_2 7'h73
`define RCR_OFF_MODE_2 7'h7A
// reset values
`define RCR_RST_CHIP_ID 8'h5A
`define RCR_RST_DAMPING 8'h19
`define RCR_RST_POWER_DOWN 8'h10
`define RCR_RST_TIME_CTRL 8'h7E
`define RCR_RST_DATA_CUTOFF 8'h7F
`define RCR_RST_TEST_CTRL_2 8'h00
`define RCR_RST_SERVO_CUTOFF 8'h5A
`define RCR_RST_SERVO_CTRL 8'h00
`define RCR_RST_DATA_BOOST 8'h00
`define RCR_RST_WRITE_PRECOMP 8'h00
`define RCR_RST_GROUP_DELAY 8'h00
`define RCR_RST_INT_MASK 8'h80
`define RCR_RST_DATA_THRESH 8'h20
`define RCR_RST_SERVO_THRESH 8'hC0
`define RCR_RST_SERVO_QUAL 8'h88
`define RCR_RST_BASELINE 8'h00
`define RCR_RST_RESYNC_1 8'h00
`define RCR_RST_TEST_CTRL_1 8'h00
`define RCR_RST_FB_DIVIDER 8'h10
`define RCR_RST_RESYNC_2 8'h00
`define RCR_RST_REF_DIVIDER 8'hEF
`define RCR_RST_DATA_RATE 8'h7F
`define RCR_RST_COAST_1 8'h40
`define RCR_RST_SEQUENCE 8'hC0
`define RCR_RST_MODE_1 8'h00
`define RCR_RST_COAST_2 8'h00
`define RCR_RST_MODE_2 8'h20
// writable masks: read-only and unused bits stay out of writes
`define RCR_WMASK_POWER_DOWN 8'hFE
`define RCR_WMASK_TEST_CTRL_2 8'h1B
`define RCR_WMASK_RESYNC 8'hC0
`define RCR_WMASK_SEQUENCE 8'hF8
`define RCR_WMASK_MODE_2 8'h3F
// field positions
`define RCR_BIT_ATO_EN 5
`define RCR_BIT_SLEEP_SCOPE 4
`define RCR_BIT_AGC_SLEEP 3
`define RCR_BIT_TB_SLEEP 2
`define RCR_BIT_SEP_SLEEP 1
`define RCR_BIT_TOP 7
`define RCR_BIT_DIG_SEL_HI 6
`define RCR_BIT_DIG_SEL_LO 0
`define RCR_BIT_BYPASS 4
`define RCR_BIT_IO_TEST 3
`define RCR_BIT_THRESH_TEST 1
`define RCR_BIT_RD_ENABLE 2
`define RCR_ATS_HI 5
`define RCR_ATS_LO 3
// serial frame: read flag, 7 address bits msb first, 8 data bits
`define RCR_FRAME_BITS 16
`endif

// ---- rcr_pkg.sv ----
// types shared by the read channel control bank
package rcr_pkg;
    typedef enum logic [1:0] {
        RCR_DTM_CP_ENABLE,
        RCR_DTM_SPLIT_SECTOR,
        RCR_DTM_RESYNC_WIN,
        RCR_DTM_WINDOW_CNT
    } rcr_dig_test_t;

    typedef struct packed {
        logic agc_filter_on;
        logic pulse_det_on;
        logic timebase_on;
        logic separator_on;
        logic full_sleep;
    } rcr_power_t;

    typedef struct packed {
        logic [6:0] cutoff;
        logic [6:0] boost;
        logic [1:0] attenuation;
        logic qualifier_style;
        logic offset_null_hold;
        logic baseline_sign;
        logic [3:0] baseline_offset;
        logic [5:0] servo_threshold;
        logic [1:0] charge_pump;
        logic read_pulse_active_low;
        logic read_pulse_enable;
    } rcr_analog_t;

    typedef struct packed {
        logic [2:0] analog_test_select;
        logic analog_test_out_enable;
        logic [6:0] ato_dac_addr;
        rcr_dig_test_t digital_test_mux;
        logic timebase_bypass;
        logic io_test_enable;
        logic threshold_test;
        logic input_impedance_select;
        logic [6:0] divider_value;
        logic tp_vco_div2;
    } rcr_test_t;
endpackage

// ---- rcr_bank.sv ----
// serial-port register bank and control decode of the read channel
`timescale 1ns/1ps
`include "rcr_regs.svh"

module rcr_bank (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic serial_clk_i,
    input wire logic serial_enable_i,
    input wire logic serial_data_i,
    output logic serial_data_o,
    output logic serial_data_oe_o,
    input wire logic servo_gate_i,
    input wire logic read_gate_i,
    input wire logic power_down_pin_i,
    input wire logic low_impedance_period_i,
    input wire logic [2:0] resync_fail_count_i,
    input wire logic [5:0] resync_begin_i,
    input wire logic [5:0] resync_end_i,
    output rcr_pkg::rcr_power_t power_o,
    output rcr_pkg::rcr_analog_t analog_o,
    output rcr_pkg::rcr_test_t test_o,
    output logic low_impedance_open_o
);
    parameter logic [7:0] CHIP_ID = `RCR_RST_CHIP_ID; // arbitrary value

    ////////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] regs [0:127];
    logic [6:0] last_dac;

    function automatic logic [7:0] wmask(input logic [6:0] a);
        case (a)
            `RCR_OFF_CHIP_ID: wmask = 8'h00;
            `RCR_OFF_POWER_DOWN: wmask = `RCR_WMASK_POWER_DOWN;
            `RCR_OFF_TEST_CTRL_2: wmask = `RCR_WMASK_TEST_CTRL_2;
            `RCR_OFF_RESYNC_1: wmask = `RCR_WMASK_RESYNC;
            `RCR_OFF_RESYNC_2: wmask = `RCR_WMASK_RESYNC;
            `RCR_OFF_SEQUENCE: wmask = `RCR_WMASK_SEQUENCE;
            `RCR_OFF_MODE_2: wmask = `RCR_WMASK_MODE_2;
            `RCR_OFF_DAMPING, `RCR_OFF_TIME_CTRL, `RCR_OFF_DATA_CUTOFF, `RCR_OFF_SERVO_CUTOFF,
            `RCR_OFF_SERVO_CTRL, `RCR_OFF_DATA_BOOST, `RCR_OFF_WRITE_PRECOMP, `RCR_OFF_GROUP_DELAY,
            `RCR_OFF_INT_MASK, `RCR_OFF_DATA_THRESH, `RCR_OFF_SERVO_THRESH, `RCR_OFF_SERVO_QUAL,
            `RCR_OFF_BASELINE, `RCR_OFF_TEST_CTRL_1, `RCR_OFF_FB_DIVIDER, `RCR_OFF_REF_DIVIDER,
            `RCR_OFF_DATA_RATE, `RCR_OFF_COAST_1, `RCR_OFF_MODE_1, `RCR_OFF_COAST_2: wmask = 8'hFF;
            default: wmask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] rst_val(input logic [6:0] a);
        case (a)
            `RCR_OFF_DAMPING: rst_val = `RCR_RST_DAMPING;
            `RCR_OFF_POWER_DOWN: rst_val = `RCR_RST_POWER_DOWN;
            `RCR_OFF_TIME_CTRL: rst_val = `RCR_RST_TIME_CTRL;
            `RCR_OFF_DATA_CUTOFF: rst_val = `RCR_RST_DATA_CUTOFF;
            `RCR_OFF_SERVO_CUTOFF: rst_val = `RCR_RST_SERVO_CUTOFF;
            `RCR_OFF_INT_MASK: rst_val = `RCR_RST_INT_MASK;
            `RCR_OFF_DATA_THRESH: rst_val = `RCR_RST_DATA_THRESH;
            `RCR_OFF_SERVO_THRESH: rst_val = `RCR_RST_SERVO_THRESH;
            `RCR_OFF_SERVO_QUAL: rst_val = `RCR_RST_SERVO_QUAL;
            `RCR_OFF_FB_DIVIDER: rst_val = `RCR_RST_FB_DIVIDER;
            `RCR_OFF_REF_DIVIDER: rst_val = `RCR_RST_REF_DIVIDER;
            `RCR_OFF_DATA_RATE: rst_val = `RCR_RST_DATA_RATE;
            `RCR_OFF_COAST_1: rst_val = `RCR_RST_COAST_1;
            `RCR_OFF_SEQUENCE: rst_val = `RCR_RST_SEQUENCE;
            `RCR_OFF_MODE_2: rst_val = `RCR_RST_MODE_2;
            default: rst_val = 8'h00;
        endcase
    endfunction

    // dac-bearing registers feed the analog test output
    function automatic logic is_dac(input logic [6:0] a);
        case (a)
            `RCR_OFF_DAMPING, `RCR_OFF_DATA_CUTOFF, `RCR_OFF_SERVO_CUTOFF, `RCR_OFF_DATA_BOOST,
            `RCR_OFF_DATA_THRESH, `RCR_OFF_SERVO_THRESH, `RCR_OFF_DATA_RATE: is_dac = 1'b1;
            default: is_dac = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // serial shifter: no power state gates it, so it works in full sleep
    logic sclk_q;
    logic sen_q;
    logic [4:0] bit_cnt;
    logic [15:0] shift;
    logic [7:0] rd_shift;
    wire sclk_rise = serial_clk_i & ~sclk_q;
    wire sclk_fall = ~serial_clk_i & sclk_q;
    wire frame_start = serial_enable_i & ~sen_q;
    wire [15:0] next_shift = {shift[14:0], serial_data_i};
    // frame bit 0 selects read, then address msb first: a3..a0 then s2..s0
    wire is_read = shift[6];
    wire addr_done = sclk_rise & (bit_cnt == 5'd7);
    wire [6:0] wr_addr = next_shift[14:8];
    wire wr_fire = sclk_rise & serial_enable_i & (bit_cnt == 5'd15) & ~next_shift[15];
    wire [7:0] wr_merge = (regs[wr_addr] & ~wmask(wr_addr)) | (next_shift[7:0] & wmask(wr_addr));

    // read-only status fields overlay the stored bits
    function automatic logic [7:0] rd_val(input logic [6:0] a);
        case (a)
            `RCR_OFF_CHIP_ID: rd_val = CHIP_ID;
            `RCR_OFF_SEQUENCE: rd_val = {regs[a][7:3], resync_fail_count_i};
            `RCR_OFF_RESYNC_1: rd_val = {regs[a][7:6], resync_begin_i};
            `RCR_OFF_RESYNC_2: rd_val = {regs[a][7:6], resync_end_i};
            default: rd_val = regs[a];
        endcase
    endfunction

    always_ff @(posedge ref_clk_i)
    begin
        sclk_q <= serial_clk_i;
        sen_q <= serial_enable_i;
        if (reset_i | ~serial_enable_i | frame_start)
        begin
            bit_cnt <= 5'd0;
            shift <= 16'h0000;
        end
        else if (sclk_rise & (bit_cnt != 5'd16))
        begin
            bit_cnt <= bit_cnt + 5'd1;
            shift <= next_shift;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i | ~serial_enable_i)
        begin
            rd_shift <= 8'h00;
            serial_data_oe_o <= 1'b0;
            serial_data_o <= 1'b0;
        end
        else if (addr_done & is_read)
        begin
            rd_shift <= rd_val({shift[5:0], serial_data_i});
            serial_data_oe_o <= 1'b1;
        end
        else if (sclk_fall & serial_data_oe_o)
        begin
            serial_data_o <= rd_shift[7];
            rd_shift <= {rd_shift[6:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < 128; i++)
                regs[i] <= rst_val(7'(i));
            last_dac <= `RCR_OFF_DATA_RATE;
        end
        else if (wr_fire)
        begin
            regs[wr_addr] <= wr_merge;
            if (is_dac(wr_addr))
                last_dac <= wr_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power decode
    wire [7:0] pd_r = regs[`RCR_OFF_POWER_DOWN];
    wire [7:0] mode1_r = regs[`RCR_OFF_MODE_1];
    wire read_data_out_enable = mode1_r[`RCR_BIT_RD_ENABLE];
    wire servo_gate = servo_gate_i;
    wire sleep_scope_select = pd_r[`RCR_BIT_SLEEP_SCOPE];
    wire full_sleep = power_down_pin_i & sleep_scope_select;
    wire sect_sleep = power_down_pin_i & ~sleep_scope_select;
    wire wake_req = servo_gate | read_data_out_enable;
    wire agc_filter_on = ~full_sleep & (~(sect_sleep & pd_r[`RCR_BIT_AGC_SLEEP]) | wake_req);
    wire timebase_on = ~full_sleep & ~(sect_sleep & pd_r[`RCR_BIT_TB_SLEEP]);
    wire separator_on = ~full_sleep & ~(sect_sleep & pd_r[`RCR_BIT_SEP_SLEEP]);
    // pulse detector shares the front-end section sleep bit
    wire pulse_det_on = ~full_sleep & (wake_req | ~(sect_sleep & pd_r[`RCR_BIT_AGC_SLEEP]));

    ////////////////////////////////////////////////////////////////////////////
    // analog and test field decode
    wire [7:0] fc_r = regs[`RCR_OFF_DATA_CUTOFF];
    wire [7:0] fcs_r = regs[`RCR_OFF_SERVO_CUTOFF];
    wire [7:0] fb_r = regs[`RCR_OFF_DATA_BOOST];
    wire [7:0] fgd_r = regs[`RCR_OFF_GROUP_DELAY];
    wire [7:0] dvt_r = regs[`RCR_OFF_DATA_THRESH];
    wire [7:0] servo_data_threshold_r = regs[`RCR_OFF_SERVO_THRESH];
    wire [7:0] blo_r = regs[`RCR_OFF_BASELINE];
    wire [7:0] ct1_r = regs[`RCR_OFF_TEST_CTRL_1];
    wire [7:0] ct2_r = regs[`RCR_OFF_TEST_CTRL_2];
    wire [7:0] n_r = regs[`RCR_OFF_FB_DIVIDER];
    // software keeps the data cutoff in 16..127; servo mode switches cutoff source
    wire [6:0] data_cutoff_value = servo_gate ? fcs_r[6:0] : fc_r[6:0];
    wire [6:0] data_boost_value = fb_r[6:0];
    wire [3:0] baseline_nibble = servo_gate ? blo_r[7:4] : blo_r[3:0];
    wire [2:0] analog_test_select = ct1_r[`RCR_ATS_HI:`RCR_ATS_LO];
    wire [1:0] dig_code = {ct1_r[`RCR_BIT_DIG_SEL_HI], ct2_r[`RCR_BIT_DIG_SEL_LO]};
    // all-ones select shows separator vco while reading, else time base output
    wire tp_vco = (analog_test_select == 3'h7) & read_gate_i;

    rcr_pkg::rcr_analog_t next_analog;
    rcr_pkg::rcr_test_t next_test;
    rcr_pkg::rcr_power_t next_power;

    always_comb
    begin
        next_power = '{agc_filter_on, pulse_det_on, timebase_on, separator_on, full_sleep};
        next_analog.cutoff = data_cutoff_value;
        next_analog.boost = data_boost_value;
        next_analog.attenuation = fgd_r[7:6];
        next_analog.qualifier_style = fb_r[`RCR_BIT_TOP];
        next_analog.offset_null_hold = fcs_r[`RCR_BIT_TOP];
        next_analog.baseline_sign = dvt_r[`RCR_BIT_TOP];
        next_analog.baseline_offset = baseline_nibble;
        next_analog.servo_threshold = servo_data_threshold_r[5:0];
        next_analog.charge_pump = servo_data_threshold_r[7:6];
        next_analog.read_pulse_active_low = fc_r[`RCR_BIT_TOP];
        next_analog.read_pulse_enable = (servo_gate | read_data_out_enable) & ~full_sleep;
        next_test.analog_test_select = analog_test_select;
        next_test.analog_test_out_enable = pd_r[`RCR_BIT_ATO_EN];
        next_test.ato_dac_addr = pd_r[`RCR_BIT_ATO_EN] ? last_dac : 7'h00;
        next_test.digital_test_mux = rcr_pkg::rcr_dig_test_t'(dig_code);
        next_test.timebase_bypass = ct2_r[`RCR_BIT_BYPASS];
        next_test.io_test_enable = ct2_r[`RCR_BIT_IO_TEST];
        next_test.threshold_test = ct2_r[`RCR_BIT_THRESH_TEST];
        next_test.input_impedance_select = n_r[`RCR_BIT_TOP];
        next_test.divider_value = n_r[6:0];
        next_test.tp_vco_div2 = tp_vco;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            power_o <= '0;
            analog_o <= '0;
            test_o <= '0;
            low_impedance_open_o <= 1'b0;
        end
        else
        begin
            power_o <= next_power;
            analog_o <= next_analog;
            test_o <= next_test;
            // open-z only matters while the low-impedance period runs
            low_impedance_open_o <= low_impedance_period_i & n_r[`RCR_BIT_TOP];
        end
    end
endmodule

// ---- rcr_host_model.sv ----
// serial port master standing in for the drive controller
`timescale 1ns/1ps
module rcr_host_model (
    input wire logic ref_clk_i,
    output logic serial_clk_o,
    output logic serial_enable_o,
    output logic serial_data_o,
    input wire logic dev_data_i,
    input wire logic dev_oe_i,
    output logic line_o
);
    logic [15:0] frame;
    // shared data wire: the device wins while it drives
    assign line_o = dev_oe_i ? dev_data_i : serial_data_o;
    initial
    begin
        serial_clk_o = 1'b0;
        serial_enable_o = 1'b0;
        serial_data_o = 1'b0;
    end
    ////////////////////////////////////////
    // clock idles low; four reference cycles per phase
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
        frame = {rd, addr, wdata};
        rdata = 8'h00;
        @(posedge ref_clk_i);
        #1;
        serial_enable_o = 1'b1;
        for (int i = 15; i >= 0; i--)
        begin
            // a released line toggles so a stale level is never read back
            serial_data_o = (rd && i < 8) ? ~serial_data_o : frame[i];
            repeat (4) @(posedge ref_clk_i);
            #1;
            if (i < 8)
                rdata[i] = line_o;
            serial_clk_o = 1'b1;
            repeat (4) @(posedge ref_clk_i);
            #1;
            serial_clk_o = 1'b0;
        end
        repeat (3) @(posedge ref_clk_i);
        #1;
        serial_enable_o = 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask
endmodule

// ---- rcr_bank_asserts.sv ----
// pin-level assertions for the read channel control bank
`timescale 1ns/1ps
module rcr_bank_asserts (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic serial_clk_i,
    input wire logic serial_enable_i,
    input wire logic serial_data_o,
    input wire logic serial_data_oe_o,
    input wire logic servo_gate_i,
    input wire logic power_down_pin_i,
    input wire logic low_impedance_period_i,
    input wire rcr_pkg::rcr_power_t power_o,
    input wire rcr_pkg::rcr_test_t test_o,
    input wire logic low_impedance_open_o
);
    default clocking cb
        @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    sequence frame_closed;
        (!serial_enable_i) [*3];
    endsequence
    sequence clk_held_high;
        (serial_data_oe_o && serial_clk_i) [*4];
    endsequence
    ////////////////////////////////////////
    a_sleep_all_off: assert property (power_o.full_sleep |-> power_o[4:1] == 4'h0)
        else $error("section awake in full sleep");
    a_gate_wakes_agc: assert property (!$past(reset_i) && $past(servo_gate_i) && !power_o.full_sleep
        |-> power_o.agc_filter_on)
        else $error("servo gate did not wake front end");
    a_gate_wakes_pulse: assert property (!$past(reset_i) && $past(servo_gate_i) && !power_o.full_sleep
        |-> power_o.pulse_det_on)
        else $error("servo gate did not wake pulse detector");
    a_pin_low_wakes: assert property (!$past(reset_i) && !$past(power_down_pin_i) |-> power_o == 5'h1E)
        else $error("section asleep with pin released");
    a_low_impedance_period_needs_period: assert property (low_impedance_open_o |-> $past(low_impedance_period_i))
        else $error("open impedance outside low impedance period");
    a_oe_after_frame: assert property (frame_closed |-> !serial_data_oe_o)
        else $error("read data driven outside a frame");
    a_data_held_high: assert property (clk_held_high |-> $stable(serial_data_o))
        else $error("read data moved while serial clock high");
    a_oe_in_frame: assert property ($rose(serial_data_oe_o) |-> serial_enable_i)
        else $error("read data enabled without frame");
    a_ato_off_zero: assert property (!test_o.analog_test_out_enable |-> test_o.ato_dac_addr == 7'h00)
        else $error("test dac routed while disabled");
endmodule
bind rcr_bank rcr_bank_asserts rcr_bank_asserts_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .serial_clk_i(serial_clk_i), .serial_enable_i(serial_enable_i), .serial_data_o(serial_data_o),
    .serial_data_oe_o(serial_data_oe_o), .servo_gate_i(servo_gate_i), .power_down_pin_i(power_down_pin_i),
    .low_impedance_period_i(low_impedance_period_i), .power_o(power_o), .test_o(test_o),
    .low_impedance_open_o(low_impedance_open_o));

// ---- testbench.sv ----
// self-checking bench for the read channel control bank
`timescale 1ns/1ps
`include "rcr_regs.svh"
module testbench;
    localparam logic [7:0] ID_VALUE = 8'hA7; // arbitrary value
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic gate = 1'b0;
    logic pin = 1'b0;
    logic low_impedance_period = 1'b0;
    logic rg = 1'b0;
    logic sclk, sen, sdi, sdo, soe, hdo, lz_open;
    logic [7:0] r;
    logic [22:0] ent;
    rcr_pkg::rcr_power_t pwr;
    rcr_pkg::rcr_analog_t ana;
    rcr_pkg::rcr_test_t tst;
    int fails = 0;
    int checked = 0;
    logic [14:0] rst_tab [8] = '{{`RCR_OFF_CHIP_ID, ID_VALUE}, {`RCR_OFF_POWER_DOWN, `RCR_RST_POWER_DOWN},
        {`RCR_OFF_DATA_CUTOFF, `RCR_RST_DATA_CUTOFF}, {`RCR_OFF_SERVO_THRESH, `RCR_RST_SERVO_THRESH},
        {`RCR_OFF_SERVO_QUAL, `RCR_RST_SERVO_QUAL}, {`RCR_OFF_SEQUENCE, 8'hC5},
        {`RCR_OFF_MODE_2, `RCR_RST_MODE_2}, {`RCR_OFF_RESYNC_2, 8'h15}};
    logic [22:0] mask_tab [7] = '{{`RCR_OFF_POWER_DOWN, 16'hFFFE}, {`RCR_OFF_TEST_CTRL_2, 16'hFF1B},
        {`RCR_OFF_MODE_2, 16'hFF3F}, {`RCR_OFF_CHIP_ID, 8'h00, ID_VALUE}, {`RCR_OFF_SEQUENCE, 16'h0705},
        {`RCR_OFF_RESYNC_1, 16'hFFEA}, {7'h05, 16'hFF00}};
    // power register, mode register 1, pin, gate, expected power outputs
    logic [22:0] pwr_tab [6] = '{{16'h1000, 2'h3, 5'h01}, {16'h0E00, 2'h2, 5'h00}, {16'h0E00, 2'h3, 5'h18},
        {16'h0E04, 2'h2, 5'h18}, {16'h0800, 2'h2, 5'h06}, {16'h0E00, 2'h0, 5'h1E}};
    always #2.5 ref_clk_i = ~ref_clk_i;
    rcr_bank #(.CHIP_ID(ID_VALUE)) rcr_bank_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .serial_clk_i(sclk),
        .serial_enable_i(sen), .serial_data_i(sdi), .serial_data_o(sdo), .serial_data_oe_o(soe),
        .servo_gate_i(gate), .read_gate_i(rg), .power_down_pin_i(pin), .low_impedance_period_i(low_impedance_period),
        .resync_fail_count_i(3'h5), .resync_begin_i(6'h2A), .resync_end_i(6'h15), .power_o(pwr),
        .analog_o(ana), .test_o(tst), .low_impedance_open_o(lz_open));
    rcr_host_model rcr_host_model_i (.ref_clk_i(ref_clk_i), .serial_clk_o(sclk), .serial_enable_o(sen),
        .serial_data_o(hdo), .dev_data_i(sdo), .dev_oe_i(soe), .line_o(sdi));
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        rcr_host_model_i.xfer(1'b0, a, d, r);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        rcr_host_model_i.xfer(1'b1, a, 8'h00, r);
        chk(r, exp);
    endtask
    task automatic settle;
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        // hang guard: a run this long means a stuck sequence
        repeat (90000) @(posedge ref_clk_i);
        fails++;
        report_and_stop();
    end
    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        #1;
        reset_i = 1'b0;
        settle();
        chk(8'(pwr), 8'h1E);
        foreach (rst_tab[k])
            rd(rst_tab[k][14:8], rst_tab[k][7:0]);
        $display("test reset values done");
        foreach (mask_tab[k])
        begin
            wr(mask_tab[k][22:16], mask_tab[k][15:8]);
            rd(mask_tab[k][22:16], mask_tab[k][7:0]);
        end
        $display("test write masks done");
        foreach (pwr_tab[k])
        begin
            ent = pwr_tab[k];
            wr(`RCR_OFF_POWER_DOWN, ent[22:15]);
            wr(`RCR_OFF_MODE_1, ent[14:7]);
            pin = ent[6];
            gate = ent[5];
            settle();
            chk(8'(pwr), 8'(ent[4:0]));
            rd(`RCR_OFF_POWER_DOWN, ent[22:15]);
        end
        $display("test power control done");
        wr(`RCR_OFF_DATA_CUTOFF, 8'h90);
        wr(`RCR_OFF_SERVO_CUTOFF, 8'hFF);
        wr(`RCR_OFF_DATA_THRESH, 8'h80);
        wr(`RCR_OFF_BASELINE, 8'h3C);
        wr(`RCR_OFF_SERVO_THRESH, 8'h95);
        wr(`RCR_OFF_GROUP_DELAY, 8'h80);
        wr(`RCR_OFF_FB_DIVIDER, 8'h85);
        wr(`RCR_OFF_POWER_DOWN, 8'h20);
        wr(`RCR_OFF_DATA_BOOST, 8'hFF);
        low_impedance_period = 1'b1;
        settle();
        chk(8'(ana.cutoff), 8'h10);
        chk(8'(ana.read_pulse_active_low), 8'h01);
        chk(8'(ana.baseline_offset), 8'h0C);
        chk(8'(ana.baseline_sign), 8'h01);
        chk(8'(ana.attenuation), 8'h02);
        chk(8'({ana.qualifier_style, ana.boost}), 8'hFF);
        chk(8'(ana.offset_null_hold), 8'h01);
        chk({ana.charge_pump, ana.servo_threshold}, 8'h95);
        chk({tst.analog_test_out_enable, tst.ato_dac_addr}, 8'hA2);
        chk({tst.divider_value, lz_open}, 8'h0B);
        chk(8'(tst.input_impedance_select), 8'h01);
        low_impedance_period = 1'b0;
        settle();
        chk(8'(lz_open), 8'h00);
        gate = 1'b1;
        settle();
        chk(8'(ana.cutoff), 8'h7F);
        chk(8'(ana.baseline_offset), 8'h03);
        chk(8'(ana.read_pulse_enable), 8'h01);
        wr(`RCR_OFF_POWER_DOWN, 8'h00);
        chk(8'(tst.ato_dac_addr), 8'h00);
        gate = 1'b0;
        wr(`RCR_OFF_MODE_1, 8'h04);
        chk(8'(ana.read_pulse_enable), 8'h01);
        wr(`RCR_OFF_MODE_1, 8'h00);
        chk(8'(ana.read_pulse_enable), 8'h00);
        $display("test field decode done");
        for (int k = 0; k < 4; k++)
        begin
            wr(`RCR_OFF_TEST_CTRL_1, {1'b0, k[1], 6'h38});
            wr(`RCR_OFF_TEST_CTRL_2, {7'h0D, k[0]});
            chk(8'(tst.digital_test_mux), 8'(k));
            chk({tst.analog_test_select, tst.timebase_bypass, tst.io_test_enable, tst.threshold_test}, 8'h3F);
        end
        rg = 1'b1;
        settle();
        chk(8'(tst.tp_vco_div2), 8'h01);
        rg = 1'b0;
        settle();
        chk(8'(tst.tp_vco_div2), 8'h00);
        wr(`RCR_OFF_TEST_CTRL_1, 8'h00);
        chk(8'(tst.analog_test_select), 8'h00);
        $display("test digital mux done");
        report_and_stop();
    end
endmodule
